/* File: hba_bus_ctrl.sv */
// Host bus handoff, ready and multiprocessor request logic.
`timescale 1ns/10ps
`include "hba_consts.svh"
module hba_bus_ctrl
  import hba_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      suspend_bus_float_n,
  input  wire logic                      host_bus_request_n,
  input  wire logic                      proc_a_select_n,
  input  wire logic                      proc_b_select_n,
  input  wire logic                      proc_c_select_n,
  input  wire logic                      proc_d_select_n,
  input  wire logic [`HBA_ID_W-1:0]      proc_identity,
  input  wire logic                      rotating_priority_sel,
  input  wire logic                      ready_active_drive_sel,
  input  wire logic                      host_access_busy,
  input  wire logic                      ext_access_req,
  input  wire logic [`HBA_NUM_REQ-1:0]   mp_bus_request_n_in,
  input  wire logic                      host_bus_grant_n_in,
  output logic      [`HBA_NUM_REQ-1:0]   mp_bus_request_n_out,
  output logic      [`HBA_NUM_REQ-1:0]   mp_bus_request_n_oe,
  output logic                           host_bus_grant_n_out,
  output logic                           host_bus_grant_n_oe,
  output logic                           host_ready_n_out,
  output logic                           host_ready_n_oe,
  output logic                           bus_drive_en,
  output logic                           ext_access_done,
  output logic                           core_stall,
  output logic                           bus_master,
  output logic      [`HBA_HIST_DW-1:0]   last_winner
);

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers for the asynchronous host inputs.
  // Two stages keep a metastable host edge away from the arbiter; the price
  // is two cycles of latency on every handoff.

  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  wire  [4:0] async_in = {host_bus_request_n, proc_d_select_n,
                          proc_c_select_n, proc_b_select_n,
                          proc_a_select_n};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire       hreq      = ~sync2_reg[4];
  wire [3:0] sel       = ~sync2_reg[3:0];
  // A single select is assumed; any select with a host request enables the ready driver while busy or in active drive.
  wire       any_sel   = |sel;
  wire       suspend   = ~suspend_bus_float_n;

  //////////////////////////////////////////////////////////////////////////
  // Arbitration among processor requests.

  function automatic logic [`HBA_ID_W-1:0] pick_winner(
    input logic [`HBA_NUM_REQ-1:0] req,
    input logic [`HBA_ID_W-1:0]    start
  );
    logic [`HBA_ID_W-1:0] idx;
    logic [`HBA_ID_W-1:0] best;
    logic                 found;
    best  = `HBA_ID_NONE;
    found = 1'b0;
    idx   = start;
    for (int i = 0; i < `HBA_NUM_REQ; i++) begin
      if (!found && req[idx - 3'h1]) begin
        best  = idx;
        found = 1'b1;
      end
      idx = (idx == 3'h6) ? 3'h1 : idx + 3'h1;
    end
    return best;
  endfunction : pick_winner

  hba_state_type        state_reg;
  hba_state_type        state_next;
  logic [`HBA_ID_W-1:0] rr_start_reg;
  logic [`HBA_HIST_AW-1:0] hist_ptr_reg;

  wire own_valid = (proc_identity >= 3'h1) && (proc_identity <= 3'h6);
  wire [`HBA_NUM_REQ-1:0] own_mask =
    own_valid ? 6'h01 << (proc_identity - 3'h1) : 6'h00;
  // Single-processor systems (identity zero) own the bus outright.
  wire want_bus  = ext_access_req;
  wire [`HBA_NUM_REQ-1:0] req_seen =
    (~mp_bus_request_n_in & ~own_mask) | (want_bus ? own_mask : 6'h00);
  wire [`HBA_ID_W-1:0] fixed_start = 3'h1;
  wire [`HBA_ID_W-1:0] winner = pick_winner(req_seen,
    rotating_priority_sel ? rr_start_reg : fixed_start);
  wire i_win = !own_valid || (winner == proc_identity);
  wire grant_seen = !host_bus_grant_n_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HBA_IDLE: begin
        if (hreq && !grant_seen && i_win) begin
          state_next = HBA_RELEASE;
        end else if (want_bus && i_win && !hreq) begin
          state_next = HBA_MASTER;
        end else if (hreq) begin
          state_next = HBA_SLAVE;
        end
      end
      HBA_MASTER: begin
        if (hreq) begin
          state_next = HBA_RELEASE;
        end else if (!want_bus) begin
          state_next = HBA_IDLE;
        end
      end
      HBA_RELEASE: begin
        state_next = hreq ? HBA_GRANTED : HBA_IDLE;
      end
      HBA_GRANTED: begin
        if (!hreq) begin
          state_next = HBA_IDLE;
        end
      end
      HBA_SLAVE: begin
        if (!hreq) begin
          state_next = HBA_IDLE;
        end
      end
      default: state_next = HBA_IDLE;
    endcase
  end

  wire is_master   = (state_reg == HBA_MASTER);
  wire drive_next  = (state_next == HBA_MASTER) && !suspend;
  wire done_next   = is_master && want_bus && !suspend && !hreq;
  wire rdy_en_next = any_sel && hreq;
  wire win_event   = (state_reg == HBA_IDLE) && (state_next == HBA_MASTER);

  //////////////////////////////////////////////////////////////////////////
  // State and registered outputs.
  // Grant, bus_drive_en and bus_master outputs follow the next state, so they change on the same edge as the
  // state register, while ext_access_done and core_stall lag it by a cycle.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= HBA_IDLE;
      rr_start_reg <= 3'h1;
      hist_ptr_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (win_event) begin
        rr_start_reg <= (winner == 3'h6) ? 3'h1 : winner + 3'h1;
        hist_ptr_reg <= hist_ptr_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mp_bus_request_n_out <= 6'h3f;
      mp_bus_request_n_oe  <= 6'h00;
      host_bus_grant_n_out <= 1'b1;
      host_bus_grant_n_oe  <= 1'b0;
      host_ready_n_out     <= 1'b1;
      host_ready_n_oe      <= 1'b0;
      bus_drive_en         <= 1'b0;
      ext_access_done      <= 1'b0;
      core_stall           <= 1'b0;
      bus_master           <= 1'b0;
    end else begin
      mp_bus_request_n_out <= want_bus ? ~own_mask : 6'h3f;
      mp_bus_request_n_oe  <= own_mask;
      host_bus_grant_n_out <= !(state_next == HBA_GRANTED);
      host_bus_grant_n_oe  <= (state_next == HBA_GRANTED);
      // Open-drain drives only the low level; active drive also drives high.
      host_ready_n_out     <= !host_access_busy;
      host_ready_n_oe      <= rdy_en_next &&
                              (host_access_busy || ready_active_drive_sel);
      bus_drive_en         <= drive_next;
      ext_access_done      <= done_next;
      core_stall           <= want_bus && !done_next;
      bus_master           <= (state_next == HBA_MASTER);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // History of arbitration winners for debug readout.

  hba_hist_mem u_hist (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (win_event),
    .wr_addr (hist_ptr_reg),
    .wr_data (6'h01 << (winner - 3'h1)),
    .rd_addr (hist_ptr_reg - 3'h1),
    .rd_data (last_winner)
  );
endmodule : hba_bus_ctrl

/* File: hba_consts.svh */
// Constants for the host bus handoff and arbitration block.
`ifndef HBA_CONSTS_SVH
`define HBA_CONSTS_SVH
`define HBA_NUM_REQ       6
`define HBA_NUM_SEL       4
`define HBA_ID_W          3
`define HBA_ID_NONE       3'h0
`define HBA_SYNC_STAGES   2
`define HBA_HIST_DEPTH    8
`define HBA_HIST_AW       3
`define HBA_HIST_DW       6
`endif

/* File: hba_pkg.sv */
// Types for the host bus handoff and arbitration block.
package hba_pkg;
  typedef enum logic [2:0] {
    HBA_IDLE,
    HBA_MASTER,
    HBA_RELEASE,
    HBA_GRANTED,
    HBA_SLAVE
  } hba_state_type;
endpackage : hba_pkg

/* File: hba_hist_mem.sv */
// Small memory of recent arbitration winners, registered read data.
`timescale 1ns/10ps
`include "hba_consts.svh"
module hba_hist_mem (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       wr_en,
  input  wire logic [`HBA_HIST_AW-1:0]    wr_addr,
  input  wire logic [`HBA_HIST_DW-1:0]    wr_data,
  input  wire logic [`HBA_HIST_AW-1:0]    rd_addr,
  output logic      [`HBA_HIST_DW-1:0]    rd_data
);
  logic [`HBA_HIST_DW-1:0]    mem_reg [`HBA_HIST_DEPTH];
  logic [`HBA_HIST_DEPTH-1:0] valid_reg;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_reg <= 8'h00;
      rd_data   <= 6'h00;
    end else begin
      if (wr_en) begin
        valid_reg[wr_addr] <= 1'b1;
      end
      // Slots never written read as zero, so the output is never unknown.
      rd_data <= valid_reg[rd_addr] ? mem_reg[rd_addr] : 6'h00;
    end
  end
endmodule : hba_hist_mem

/* File: hba_check_sva.sv */
// Checker for the bus handoff, ready and request outputs.
`timescale 1ns/10ps
module hba_check_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       suspend_bus_float_n,
  input wire logic       host_bus_request_n,
  input wire logic [2:0] proc_identity,
  input wire logic       ready_active_drive_sel,
  input wire logic       host_access_busy,
  input wire logic [5:0] mp_bus_request_n_oe,
  input wire logic       host_bus_grant_n_out,
  input wire logic       host_bus_grant_n_oe,
  input wire logic       host_ready_n_out,
  input wire logic       host_ready_n_oe,
  input wire logic       bus_drive_en,
  input wire logic       ext_access_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_float_susp: assert property (!suspend_bus_float_n |=> !bus_drive_en)
    else $error("bus driven after suspend");
  a_stall_susp: assert property (!suspend_bus_float_n |=> !ext_access_done)
    else $error("access done under suspend");
  a_done_driven: assert property (ext_access_done |-> bus_drive_en)
    else $error("access done with bus floated");
  a_float_grant: assert property ($rose(host_bus_grant_n_oe) |->
    $past(!bus_drive_en) && !bus_drive_en) else $error("grant before float");
  a_grant_cause: assert property (host_bus_grant_n_oe |->
    !host_bus_grant_n_out && $past(!host_bus_request_n, 3))
    else $error("grant without request");
  a_grant_hold: assert property (host_bus_grant_n_oe && !host_bus_request_n
    |=> host_bus_grant_n_oe) else $error("grant dropped early");
  a_grant_drop: assert property ($rose(host_bus_request_n) |->
    ##[1:4] !host_bus_grant_n_oe) else $error("grant held too long");
  a_own_line: assert property (|mp_bus_request_n_oe |-> mp_bus_request_n_oe
    == (6'h01 << ($past(proc_identity) - 3'h1))) else $error("foreign line");
  a_ready_idle: assert property (host_bus_request_n [*5] |->
    !host_ready_n_oe) else $error("ready driven without request");
  a_ready_wait: assert property (host_ready_n_oe |->
    host_ready_n_out == !$past(host_access_busy)) else $error("ready level");
  a_ready_od: assert property (host_ready_n_oe &&
    !$past(ready_active_drive_sel) |-> !host_ready_n_out)
    else $error("ready driven high in open drain");
  c_grant: cover property ($rose(host_bus_grant_n_oe));
  c_susp: cover property (!suspend_bus_float_n && !bus_drive_en);
  c_ready: cover property (host_ready_n_oe && !host_ready_n_out);
endmodule : hba_check_sva

/* File: hba_peer_model.sv */
// Peer processors and pull-ups on the shared request and grant wires.
`timescale 1ns/10ps
module hba_peer_model (
  input  wire logic [5:0] own_out,
  input  wire logic [5:0] own_oe,
  input  wire logic       grant_out,
  input  wire logic       grant_oe,
  input  wire logic [5:0] peer_req,
  output logic      [5:0] req_wire,
  output logic            grant_wire
);
  // Peers drive only lines the block leaves free; idle lines float high.
  assign req_wire = (own_oe & own_out) | (~own_oe & ~peer_req);
  // Peers are slaves here, so only the block may pull the grant wire.
  assign grant_wire = grant_oe ? grant_out : 1'b1;
endmodule : hba_peer_model

/* File: hba_bus_ctrl_bench.sv */
// Self-checking bench for the bus handoff and arbitration block.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module hba_bus_ctrl_bench;
  logic       clk, rst, susp_n, hbr_n, rps, ads, busy, xreq;
  logic [3:0] sel_n;
  logic [2:0] ident;
  logic [5:0] peer, req_w, req_o, req_e, lw;
  logic       g_w, g_o, g_e, rdy_o, rdy_e, drv, done, stall, mst;
  int         fail_count, check_count;
  hba_bus_ctrl dut_u (.clk(clk), .rst(rst), .suspend_bus_float_n(susp_n),
    .host_bus_request_n(hbr_n), .proc_a_select_n(sel_n[0]),
    .proc_b_select_n(sel_n[1]), .proc_c_select_n(sel_n[2]),
    .proc_d_select_n(sel_n[3]), .proc_identity(ident),
    .rotating_priority_sel(rps), .ready_active_drive_sel(ads),
    .host_access_busy(busy), .ext_access_req(xreq),
    .mp_bus_request_n_in(req_w), .host_bus_grant_n_in(g_w),
    .mp_bus_request_n_out(req_o), .mp_bus_request_n_oe(req_e),
    .host_bus_grant_n_out(g_o), .host_bus_grant_n_oe(g_e),
    .host_ready_n_out(rdy_o), .host_ready_n_oe(rdy_e), .bus_drive_en(drv),
    .ext_access_done(done), .core_stall(stall), .bus_master(mst),
    .last_winner(lw));
  hba_peer_model peer_u (.own_out(req_o), .own_oe(req_e), .grant_out(g_o),
    .grant_oe(g_e), .peer_req(peer), .req_wire(req_w), .grant_wire(g_w));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] own_mask(logic [2:0] id);
    return (id == 3'h0) ? 6'h00 : 6'h01 << (id - 3'h1);
  endfunction : own_mask
  // After its own win a processor goes to the back of the rotating queue.
  function automatic logic exp_win(logic [5:0] p, logic [2:0] id, logic rot);
    return rot ? (p == 6'h00) : ((p & (own_mask(id) - 6'h01)) == 6'h00);
  endfunction : exp_win
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wait_for(ref logic s, input logic v, input string n);
    for (int i = 0; i < 20 && s !== v; i++) tick(1);
    `CHK(n, v, s)
  endtask : wait_for
  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20us;
    fail_count++;
    give_verdict;
  end
  initial begin
    {rst, susp_n, hbr_n, sel_n, ident, rps, ads, busy, xreq, peer} = 20'hf_e000;
    void'($urandom(32'hb546));
    tick(8);
    rst = 0;
    tick(2);
    // A lone processor owns the bus; suspend must stall it mid-access.
    xreq = 1;
    wait_for(done, 1'b1, "done");
    susp_n = 0;
    tick(2);
    `CHK("float", 1'b0, drv)
    `CHK("done", 1'b0, done)
    `CHK("stall", 1'b1, stall)
    susp_n = 1;
    wait_for(done, 1'b1, "resume");
    repeat (4) begin
      peer = 6'($urandom);
      rps = 1'($urandom);
      hbr_n = 0;
      wait_for(g_e, 1'b1, "grant");
      `CHK("grant", 1'b0, g_w)
      `CHK("float", 1'b0, drv)
      tick(1 + $urandom % 8);
      `CHK("held", 1'b1, g_e)
      hbr_n = 1;
      wait_for(g_e, 1'b0, "ungrant");
      wait_for(done, 1'b1, "regain");
    end
    ident = 3'h1;
    sel_n = 4'he;
    hbr_n = 0;
    for (int k = 0; k < 4; k++) begin
      {ads, busy} = 2'(k);
      tick(4);
      `CHK("rdy_oe", ads | busy, rdy_e)
      `CHK("rdy", ~busy, rdy_o)
    end
    sel_n = 4'hf;
    tick(5);
    `CHK("rdy_nosel", 1'b0, rdy_e)
    hbr_n = 1;
    sel_n = 4'he;
    tick(5);
    `CHK("rdy_noreq", 1'b0, rdy_e)
    for (int k = 1; k <= 6; k++) begin
      ident = 3'(k);
      peer = 6'($urandom);
      tick(3);
      `CHK("req_oe", own_mask(ident), req_e)
      `CHK("req_wire", 6'h00, req_w & own_mask(ident))
    end
    for (int k = 0; k < 6; k++) begin
      xreq = 0;
      peer = 6'h00;
      ident = 3'(1 + $urandom % 6);
      tick(3);
      xreq = 1;
      wait_for(done, 1'b1, "own_win");
      tick(2);
      `CHK("master", 1'b1, mst)
      `CHK("winner", own_mask(ident), lw)
      xreq = 0;
      peer = (k == 0) ? ~own_mask(ident) : 6'($urandom) & ~own_mask(ident);
      rps = 1'($urandom);
      tick(3);
      xreq = 1;
      tick(4);
      `CHK("arb", exp_win(peer, ident, rps), mst)
      `CHK("arb_stall", ~exp_win(peer, ident, rps), stall)
    end
    give_verdict;
  end
endmodule : hba_bus_ctrl_bench
bind hba_bus_ctrl hba_check_sva chk_u (
  .clk                    (clk),
  .rst                    (rst),
  .suspend_bus_float_n    (suspend_bus_float_n),
  .host_bus_request_n     (host_bus_request_n),
  .proc_identity          (proc_identity),
  .ready_active_drive_sel (ready_active_drive_sel),
  .host_access_busy       (host_access_busy),
  .mp_bus_request_n_oe    (mp_bus_request_n_oe),
  .host_bus_grant_n_out   (host_bus_grant_n_out),
  .host_bus_grant_n_oe    (host_bus_grant_n_oe),
  .host_ready_n_out       (host_ready_n_out),
  .host_ready_n_oe        (host_ready_n_oe),
  .bus_drive_en           (bus_drive_en),
  .ext_access_done        (ext_access_done)
);
